// File: rtl/tssb_pkg.sv
/*
 * tssb_pkg: shared constants and types of the three-wire serial slave with
 * busy handshake.
 * Assumes: included by every design file through tssb_pkg::*.
 */
package tssb_pkg;

    // bits carried per transfer in each direction
    localparam int unsigned TSSB_DATA_BITS = 8;
    // counter width for the bit position inside a byte
    localparam int unsigned TSSB_CNT_W     = 3;
    // last bit index, where a transfer completes
    localparam logic [2:0]  TSSB_LAST_BIT  = 3'h7;
    // serial data output level before the first transfer
    localparam logic        TSSB_SO_RESET  = 1'h1;
    // busy level after reset: not ready until a byte is loaded
    localparam logic        TSSB_BUSY_RESET = 1'h1;
    // serial clock idles high in the first phase type
    localparam logic        TSSB_SCK_IDLE  = 1'h1;
    // synchroniser depth for pin inputs
    localparam int unsigned TSSB_SYNC_STAGES = 2;
    // entries of the receive buffer
    localparam int unsigned TSSB_RXBUF_DEPTH = 2;

    // handshake state of the channel
    typedef enum logic [1:0] {
        TSSB_ST_LOAD  = 2'b00,  // busy high, waiting for the next transmit byte
        TSSB_ST_READY = 2'b01,  // busy low, master may start
        TSSB_ST_XFER  = 2'b10,  // clock edges have arrived, byte in flight
        TSSB_ST_DONE  = 2'b11   // byte complete, handing received data on
    } tssb_state_t;

endpackage

// File: rtl/tssb_rxbuf.sv
/*
 * tssb_rxbuf: small valid/ready buffer for received bytes.
 * Assumes: single clock; the drain side may stall indefinitely.
 */
`timescale 1ns/1ps
module tssb_rxbuf
    import tssb_pkg::*;
#(
    parameter int unsigned WIDTH = TSSB_DATA_BITS,
    parameter int unsigned DEPTH = TSSB_RXBUF_DEPTH
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW-1:0]    rd_ptr_d;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic [WIDTH-1:0] head_d;
    logic             push;
    logic             pop;

    // honest full and empty from the occupancy count
    assign in_ready  = (count_q != (PW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    assign pop       = out_valid_q && out_ready;
    assign count_d   = count_q + (PW+1)'(push) - (PW+1)'(pop);
    assign rd_ptr_d  = !pop ? rd_ptr_q
                     : ((rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'h1);
    // head after this edge; a word pushed into an emptying buffer bypasses memory
    assign head_d    = (push && (wr_ptr_q == rd_ptr_d)) ? in_data : mem_q[rd_ptr_d];
    // drain side comes straight from flops so the top outputs are registered
    assign out_valid = out_valid_q;
    assign out_data  = out_data_q;

    ////////////////////////////////////////////////////////////////////////
    // storage and head register are not reset; the valid flag guards every read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
        out_data_q <= head_d;
    end

    // pointers wrap at depth
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q    <= '0;
            count_q     <= '0;
            out_valid_q <= 1'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            rd_ptr_q    <= rd_ptr_d;
            count_q     <= count_d;
            out_valid_q <= (count_d != '0);
        end
    end

endmodule

// File: rtl/tssb_slave.sv
/*
 * tssb_slave: three-wire serial slave channel with a busy handshake line.
 * Holds the shift register, the serial data buffer, the handshake state
 * machine and a small receive buffer towards the local logic.
 * Assumes: the master drives the serial clock (idle high) and data in, and
 * watches busy; local logic supplies transmit bytes and drains received ones.
 */
`timescale 1ns/1ps
module tssb_slave
    import tssb_pkg::*;
#(
    parameter int unsigned RXBUF_DEPTH = TSSB_RXBUF_DEPTH
) (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    // control from local logic
    input  wire logic                      channel_en,
    input  wire logic                      early_busy_en,
    // serial link pins
    input  wire logic                      sck_in,
    input  wire logic                      si_in,
    output logic                           so_out,
    output logic                           busy_out,
    // transmit byte from local logic
    input  wire logic                      tx_valid,
    output logic                           tx_ready,
    input  wire logic [TSSB_DATA_BITS-1:0] tx_data,
    // received byte to local logic
    output logic                           rx_valid,
    input  wire logic                      rx_ready,
    output logic      [TSSB_DATA_BITS-1:0] rx_data,
    // transfer end event
    output logic                           transfer_end_irq
);

    tssb_state_t              state_q;
    tssb_state_t              state_d;
    logic [TSSB_DATA_BITS-1:0] serial_data_buffer_q;
    logic [TSSB_DATA_BITS-1:0] shift_q;
    logic [TSSB_CNT_W-1:0]     bit_cnt_q;
    logic                      sck_s;
    logic                      si_s;
    logic                      sck_prev_q;
    logic                      so_q;
    logic                      busy_q;
    logic                      irq_q;
    logic                      tx_ready_q;
    logic                      sck_fall;
    logic                      sck_rise;
    logic                      xfer_end;
    logic                      first_fall;
    logic                      rx_push;
    logic                      rx_room;
    logic                      tx_take;
    logic [TSSB_DATA_BITS-1:0] rx_byte;

    ////////////////////////////////////////////////////////////////////////
    // pin inputs pass two flops; the clock pin is sampled, not used as a clock
    tssb_sync #(
        .WIDTH (2),
        .INIT  ({TSSB_SCK_IDLE, 1'h1})
    ) u_sync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in ({sck_in, si_in}),
        .sync_out ({sck_s, si_s})
    );

    // edge detection on the synchronised clock only
    assign sck_fall   = channel_en && sck_prev_q && !sck_s;
    assign sck_rise   = channel_en && !sck_prev_q && sck_s;
    assign first_fall = sck_fall && (bit_cnt_q == '0);
    assign xfer_end   = sck_rise && (bit_cnt_q == TSSB_LAST_BIT);
    assign rx_byte    = {shift_q[TSSB_DATA_BITS-2:0], si_s};

    // handshake decoding
    assign rx_push = (state_q == TSSB_ST_DONE);
    assign tx_take = (state_q == TSSB_ST_LOAD) && tx_ready_q && tx_valid;

    ////////////////////////////////////////////////////////////////////////
    // previous synchronised clock level for edge finding
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_prev_q <= TSSB_SCK_IDLE;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    // shifter: runs on clock edges whatever busy shows
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
            so_q      <= TSSB_SO_RESET;
        end else begin
            if (first_fall) begin
                shift_q <= serial_data_buffer_q;
                so_q    <= serial_data_buffer_q[TSSB_DATA_BITS-1];
            end else if (sck_fall) begin
                so_q    <= shift_q[TSSB_DATA_BITS-1];
            end
            if (sck_rise) begin
                shift_q   <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 1'b1;                    // wraps after eight
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: a byte ending wins over every handshake step
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TSSB_ST_LOAD: begin
                if (tx_take) begin
                    state_d = TSSB_ST_READY;
                end
            end
            TSSB_ST_READY: begin
                if (first_fall) begin
                    state_d = TSSB_ST_XFER;
                end
            end
            TSSB_ST_XFER: begin
                state_d = TSSB_ST_XFER;
            end
            TSSB_ST_DONE: begin
                if (rx_room) begin
                    state_d = TSSB_ST_LOAD;
                end
            end
        endcase
        if (xfer_end) begin
            state_d = TSSB_ST_DONE;
        end
    end

    // state, buffer and handshake flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q              <= TSSB_ST_LOAD;
            serial_data_buffer_q <= '0;
            busy_q               <= TSSB_BUSY_RESET;
            irq_q                <= 1'b0;
            tx_ready_q           <= 1'b0;
        end else begin
            state_q    <= state_d;
            irq_q      <= xfer_end;
            tx_ready_q <= (state_d == TSSB_ST_LOAD) && !tx_take;
            if (xfer_end) begin
                serial_data_buffer_q <= rx_byte;
                busy_q               <= 1'b1;
            end else if (tx_take) begin
                serial_data_buffer_q <= tx_data;
                busy_q               <= 1'b0;
            end else if (first_fall && early_busy_en) begin
                busy_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // received bytes queue here; a full buffer holds busy high (back-pressure)
    tssb_rxbuf #(
        .WIDTH (TSSB_DATA_BITS),
        .DEPTH (RXBUF_DEPTH)
    ) u_rxbuf (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (rx_push),
        .in_ready  (rx_room),
        .in_data   (serial_data_buffer_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // outputs straight from flops
    assign so_out           = so_q;
    assign busy_out         = busy_q;
    assign transfer_end_irq = irq_q;
    assign tx_ready         = tx_ready_q;

endmodule

// File: rtl/tssb_sync.sv
/*
 * tssb_sync: two flip-flop synchroniser for a group of pin inputs.
 * Assumes: inputs are asynchronous to clk; only the last stage is read outside.
 */
`timescale 1ns/1ps
module tssb_sync
    import tssb_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // asynchronous inputs and their synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;   // first stage, read only by the second

    ////////////////////////////////////////////////////////////////////////
    // two stages; the first may go metastable and is never decoded
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q   <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// File: verif/tssb_master_model.sv
/* tssb_master_model: serial master, clock idle high, paced by busy falls.
   Assumes: the slave synchronises sck and si itself; 80 ns link clock. */
`timescale 1ns/1ps
module tssb_master_model (
    // link pins
    output logic      sck,
    output logic      si,
    input  wire logic busy,
    input  wire logic so
);
    ////////////////////////////////////////////////////////////////////////////////
    logic busy_fell = 1'h0;
    initial begin
        sck = 1'h1;
        si = 1'h1;
    end
    // caught by edge, not polled, so a short busy pulse is never missed
    always @(negedge busy) busy_fell = 1'h1;
    // one byte each way, msb first: out on the fall, sampled on the rise
    task automatic xfer(input logic [7:0] tx, input bit wait_fall,
                        output logic [7:0] rx, output bit ok);
        int n;
        n = 0;
        while (wait_fall && !busy_fell && n < 800) begin
            #4;
            n++;
        end
        ok = !wait_fall || busy_fell;
        busy_fell = 1'h0;
        #1.7; // phase unrelated to ref_clk
        for (int i = 7; i >= 0; i--) begin
            sck = 1'h0;
            si = tx[i];
            #40;
            sck = 1'h1;
            rx[i] = so;
            #40;
        end
        si = ~si; // a released line shows the inverse of its last bit
    endtask
endmodule

// File: verif/tssb_slave_checker.sv
/* tssb_slave_checker: handshake, link and stream assertions on the slave ports.
   Assumes: bound onto every tssb_slave; everything sampled on ref_clk. */
`timescale 1ns/1ps
module tssb_slave_checker
    import tssb_pkg::*;
#(
    parameter int unsigned RXBUF_DEPTH = TSSB_RXBUF_DEPTH
) (
    // clock and reset
    input wire logic                      ref_clk,
    input wire logic                      arst_n,
    // control and link pins
    input wire logic                      channel_en,
    input wire logic                      early_busy_en,
    input wire logic                      sck_in,
    input wire logic                      si_in,
    input wire logic                      so_out,
    input wire logic                      busy_out,
    // local streams and event
    input wire logic                      tx_valid,
    input wire logic                      tx_ready,
    input wire logic [TSSB_DATA_BITS-1:0] tx_data,
    input wire logic                      rx_valid,
    input wire logic                      rx_ready,
    input wire logic [TSSB_DATA_BITS-1:0] rx_data,
    input wire logic                      transfer_end_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // cycles since the clock pin was seen low; saturates so it never wraps to zero
    logic [3:0] sck_age_q;
    logic [3:0] sck_age_d;
    assign sck_age_d = !sck_in ? 4'h0 : (sck_age_q == 4'hf ? sck_age_q : sck_age_q + 4'h1);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            sck_age_q <= 4'hf;
        else
            sck_age_q <= sck_age_d;
    end
    // checks
    chk_reset_idle: assert property ($rose(arst_n) |-> busy_out && so_out)
        else $error("busy or serial output not high after reset");
    chk_so_on_fall: assert property (!$stable(so_out) |-> sck_age_q <= 4'h6)
        else $error("serial output moved without a clock fall");
    chk_busy_after_load: assert property ($fell(busy_out) |-> $past(tx_valid && tx_ready))
        else $error("busy fell without a byte loaded");
    chk_tx_only_busy: assert property (tx_ready |-> busy_out)
        else $error("byte accepted while busy low");
    chk_irq_one_cycle: assert property (transfer_end_irq |=> !transfer_end_irq)
        else $error("end pulse longer than one cycle");
    chk_irq_busy_high: assert property (transfer_end_irq |-> busy_out)
        else $error("busy low at byte end");
    chk_busy_rise_cause: assert property ($rose(busy_out) && !early_busy_en |-> transfer_end_irq)
        else $error("busy rose without a byte end");
    chk_early_busy: assert property (early_busy_en && channel_en && !busy_out
        && $fell(sck_in) |-> ##[1:8] busy_out)
        else $error("busy not raised after first clock fall");
    chk_irq_to_rx: assert property (transfer_end_irq |-> ##[1:3] rx_valid)
        else $error("received byte not offered after byte end");
    chk_rx_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received byte lost under stall");
    cov_byte_end: cover property (transfer_end_irq);
    cov_early: cover property (early_busy_en && $rose(busy_out));
    cov_rx_stall: cover property ((rx_valid && !rx_ready) [*8]);
endmodule

bind tssb_slave tssb_slave_checker #(.RXBUF_DEPTH(RXBUF_DEPTH)) u_chk (
    .ref_clk, .arst_n, .channel_en, .early_busy_en, .sck_in, .si_in, .so_out,
    .busy_out, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .transfer_end_irq);

// File: verif/tssb_slave_test.sv
/* tssb_slave_test: directed bench for the serial slave and its busy handshake.
   Assumes: tssb_master_model drives the link; 4 ns ref_clk. */
`timescale 1ns/1ps
module tssb_slave_test;
    import tssb_pkg::*;
    logic       ref_clk, arst_n, channel_en, early_busy_en, sck_in, si_in, so_out;
    logic       busy_out, tx_valid, tx_ready, rx_valid, rx_ready, transfer_end_irq;
    logic [7:0] tx_data, rx_data, r;
    bit         ok;
    int         fails = 0, checks = 0, irqs = 0;
    tssb_slave u_dut (.ref_clk, .arst_n, .channel_en, .early_busy_en, .sck_in, .si_in,
        .so_out, .busy_out, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
        .transfer_end_irq);
    tssb_master_model u_master (.sck(sck_in), .si(si_in), .busy(busy_out), .so(so_out));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    // a two-cycle pulse counts twice, which the counts below catch
    always @(posedge ref_clk) if (transfer_end_irq === 1'h1) irqs++;
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic bail(bit bad);
        if (bad) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic wait_busy(logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (busy_out !== lvl && n < 400);
        bail(busy_out !== lvl);
    endtask
    task automatic offer(logic [7:0] b);
        @(posedge ref_clk);
        tx_data <= b;
        tx_valid <= 1'h1;
        wait_busy(1'h0);
        @(posedge ref_clk);
        tx_valid <= 1'h0;
    endtask
    task automatic run(logic [7:0] tx, logic [7:0] exp, bit w);
        u_master.xfer(tx, w, r, ok);
        bail(!ok);
        check("master rx", r, exp);
    endtask
    task automatic pop(logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (rx_valid !== 1'h1 && n < 100);
        bail(rx_valid !== 1'h1);
        check("rx_data", rx_data, exp);
        @(posedge ref_clk);
        rx_ready <= 1'h1;
        @(posedge ref_clk);
        rx_ready <= 1'h0;
    endtask
    // scenarios
    task automatic sc_basic();
        @(negedge ref_clk);
        check("so_out idle", {7'h0, so_out}, 8'h01);
        check("busy reset", {7'h0, busy_out}, 8'h01);
        offer(8'ha4);
        run(8'h3c, 8'ha4, 1'b1);
        repeat (8) @(negedge ref_clk);
        check("busy after end", {7'h0, busy_out}, 8'h01);
        check("irq count", 8'(irqs), 8'h01);
        check("so_out held", {7'h0, so_out}, 8'h00);
        pop(8'h3c);
    endtask
    task automatic sc_disabled();
        offer(8'h81);
        channel_en <= 1'h0;
        u_master.xfer(8'hff, 1'b1, r, ok);
        @(negedge ref_clk);
        check("irq disabled", 8'(irqs), 8'h01);
        check("busy disabled", {7'h0, busy_out}, 8'h00);
        @(posedge ref_clk);
        channel_en <= 1'h1;
        run(8'h42, 8'h81, 1'b0);
        pop(8'h42);
    endtask
    task automatic sc_early();
        early_busy_en <= 1'h1;
        offer(8'h0f);
        fork
            run(8'hf0, 8'h0f, 1'b1);
            begin
                #60;
                @(negedge ref_clk);
                check("early busy", {7'h0, busy_out}, 8'h01);
            end
        join
        pop(8'hf0);
        early_busy_en <= 1'h0;
    endtask
    task automatic sc_fill();
        for (int i = 0; i < 3; i++) begin
            offer(8'h10 + 8'(i));
            run(8'h20 + 8'(i), 8'h10 + 8'(i), 1'b1);
        end
        repeat (40) @(negedge ref_clk);
        check("busy full", {7'h0, busy_out}, 8'h01);
        check("tx_ready full", {7'h0, tx_ready}, 8'h00);
        for (int i = 0; i < 3; i++) pop(8'h20 + 8'(i));
        offer(8'h66);
    endtask
    initial begin
        arst_n = 1'h0;
        channel_en = 1'h1;
        early_busy_en = 1'h0;
        tx_valid = 1'h0;
        tx_data = 8'h00;
        rx_ready = 1'h0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'h1;
        sc_basic();
        sc_disabled();
        sc_early();
        sc_fill();
        give_verdict();
    end
endmodule
